// >>> lfsc_pkg.sv
// package for the led fault status and clear register bank
// assumes a 32-bit apb slave with byte offsets at index times four
package lfsc_pkg;
  // ----------------------------------------
  // register indices and byte addresses
  // ----------------------------------------
  localparam logic [7:0] SUMMARY_IDX = 8'h64;
  localparam logic [7:0] OPEN_FLAGS_0_7_IDX = 8'h65;
  localparam logic [7:0] OPEN_FLAGS_8_15_IDX = 8'h66;
  localparam logic [7:0] OPEN_FLAGS_16_17_IDX = 8'h67;
  localparam logic [7:0] SHORT_FLAGS_0_7_IDX = 8'h86;
  localparam logic [7:0] SHORT_FLAGS_8_15_IDX = 8'h87;
  localparam logic [7:0] SHORT_FLAGS_16_17_IDX = 8'h88;
  localparam logic [7:0] OPEN_CLEAR_IDX = 8'ha7;
  localparam logic [7:0] SHORT_CLEAR_IDX = 8'ha8;
  localparam logic [7:0] SOFT_RESET_IDX = 8'ha9;
  localparam logic [7:0] IRQ_STATUS_IDX = 8'hb0;
  localparam logic [7:0] IRQ_MASK_IDX = 8'hb1;
  localparam int ADDR_W = 10;
  // ----------------------------------------
  // fields, commands, reset values
  // ----------------------------------------
  localparam int SINKS = 18;
  localparam logic [3:0] CLEAR_CMD = 4'hf;
  localparam logic [7:0] SOFT_RESET_CMD = 8'hff;
  localparam logic [17:0] FLAGS_RST = 18'h00000;
  localparam logic [1:0] IRQ_RST = 2'h0;
  localparam int IRQ_OPEN_BIT = 1;
  localparam int IRQ_SHORT_BIT = 0;
  localparam int SYNC_STAGES = 3;
  typedef struct packed {
    logic [SINKS-1:0] open;
    logic [SINKS-1:0] short;
  } lfsc_fault_t;
  typedef struct packed {
    logic sel;
    logic en;
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
  } lfsc_apb_req_t;
  function automatic logic [ADDR_W-1:0] lfscByteAddr(input logic [7:0] idx);
    return {idx, 2'b00};
  endfunction : lfscByteAddr
endpackage : lfsc_pkg

// >>> lfsc_sync.sv
// three-flop synchroniser bank for the fault detector lines
// assumes detector levels are asynchronous to clk
`timescale 1ns/1ps
module lfsc_sync import lfsc_pkg::*; #(
  parameter int WIDTH = 36
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] rise
);
  logic [WIDTH-1:0] s1_r;
  logic [WIDTH-1:0] s2_r;
  logic [WIDTH-1:0] s3_r;
  // a level counts once stages two and three are both high; a level, not an edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  assign rise = s2_r & s3_r;
endmodule : lfsc_sync

// >>> lfsc_apb_if.sv
// apb slave front end: decodes a transfer into access strobes
// assumes an apb master on clk; always answers with zero wait states
`timescale 1ns/1ps
module lfsc_apb_if import lfsc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire lfsc_apb_req_t req,
  output logic pready,
  output logic pslverr,
  output logic wrStb,
  output logic rdStb,
  output logic [7:0] idx,
  output logic hit
);
  function automatic logic isMapped(input logic [7:0] i);
    case (i)
      SUMMARY_IDX, OPEN_FLAGS_0_7_IDX, OPEN_FLAGS_8_15_IDX, OPEN_FLAGS_16_17_IDX,
      SHORT_FLAGS_0_7_IDX, SHORT_FLAGS_8_15_IDX, SHORT_FLAGS_16_17_IDX,
      OPEN_CLEAR_IDX, SHORT_CLEAR_IDX, SOFT_RESET_IDX, IRQ_STATUS_IDX, IRQ_MASK_IDX: return 1'b1;
      default: return 1'b0;
    endcase
  endfunction : isMapped
  logic access;
  assign access = req.sel & req.en;
  assign idx = req.addr[ADDR_W-1:2];
  assign hit = isMapped(idx) & (req.addr[1:0] == 2'b00);
  assign pready = access;
  // unmapped or misaligned access answers with an error, no effect
  assign pslverr = access & ~hit;
  assign wrStb = access & req.write & hit;
  assign rdStb = access & ~req.write & hit;
endmodule : lfsc_apb_if

// >>> lfsc_fault_regs.sv
// led fault flag and clear register bank, apb slave
// assumes detector outputs are async levels, two per sink (open and short)
//
// Overview of operation
// R1: open flags of sinks 17 and 16 read in bits 1 and 0 of the third open byte, upper bits zero.
// R2: short flags of sinks 7..0 read at 86h, read-only, reset to zero.
// R3: short flags of sinks 15..8 read at 87h, read-only, reset to zero.
// R4: short flags of sinks 17 and 16 read in bits 1 and 0 at 88h, upper bits zero.
// R5: writing Fh to the low nibble at A7h clears all open flags and the global open bit.
// R6: writing Fh to the low nibble at A8h clears all short flags and the global short bit.
// R7: software never writes unlisted offsets in the reset group.
// R8: a software reset register sits at A9h.
// R9: writing FFh to A9h returns every register to its default.
// R10: global open and short summary bits follow any set sink flag.
// R11: sink flags stay set until cleared or reset; other clear values do nothing.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
module lfsc_fault_regs import lfsc_pkg::*; (
  input wire logic clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lfsc_fault_t faultIn,
  output logic globalOpen,
  output logic globalShort,
  output logic irq
);
  // ----------------------------------------
  // bus front end and detector sync
  // ----------------------------------------
  lfsc_apb_req_t req;
  logic wrStb;
  logic rdStb;
  logic [7:0] idx;
  logic hit;
  logic [2*SINKS-1:0] detRise;
  lfsc_fault_t det;
  assign req = '{sel: psel, en: penable, write: pwrite, addr: paddr, wdata: pwdata};
  lfsc_apb_if uBus (
    .clk(clk),
    .rstn(rstn),
    .req(req),
    .pready(pready),
    .pslverr(pslverr),
    .wrStb(wrStb),
    .rdStb(rdStb),
    .idx(idx),
    .hit(hit)
  );
  lfsc_sync #(.WIDTH(2*SINKS)) uSync (
    .clk(clk),
    .rstn(rstn),
    .din(faultIn),
    .rise(detRise)
  );
  assign det = detRise;
  // ----------------------------------------
  // commands
  // ----------------------------------------
  logic clrOpen;
  logic clrShort;
  logic softRst;
  assign clrOpen = wrStb && idx == OPEN_CLEAR_IDX && pwdata[3:0] == CLEAR_CMD; // R5 R11
  assign clrShort = wrStb && idx == SHORT_CLEAR_IDX && pwdata[3:0] == CLEAR_CMD; // R6 R11
  assign softRst = wrStb && idx == SOFT_RESET_IDX && pwdata[7:0] == SOFT_RESET_CMD; // R8 R9
  // ----------------------------------------
  // sticky sink flags
  // ----------------------------------------
  logic [SINKS-1:0] openFlags_r;
  logic [SINKS-1:0] shortFlags_r;
  // detection wins over a clear in the same cycle so no fault is lost
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      openFlags_r <= FLAGS_RST;
    end else if (softRst) begin
      openFlags_r <= FLAGS_RST; // R9
    end else begin
      openFlags_r <= (clrOpen ? FLAGS_RST : openFlags_r) | det.open; // R5 R11
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      shortFlags_r <= FLAGS_RST;
    end else if (softRst) begin
      shortFlags_r <= FLAGS_RST; // R9
    end else begin
      shortFlags_r <= (clrShort ? FLAGS_RST : shortFlags_r) | det.short; // R6 R11
    end
  end
  assign globalOpen = |openFlags_r; // R10
  assign globalShort = |shortFlags_r; // R10
  // ----------------------------------------
  // interrupt status and mask
  // ----------------------------------------
  logic [1:0] irqStatus_r;
  logic [1:0] irqMask_r;
  logic [1:0] irqEvt;
  assign irqEvt[IRQ_OPEN_BIT] = |det.open;
  assign irqEvt[IRQ_SHORT_BIT] = |det.short;
  // write-one-to-clear; a new event in the same cycle stays set
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqStatus_r <= IRQ_RST;
    end else if (softRst) begin
      irqStatus_r <= IRQ_RST;
    end else if (wrStb && idx == IRQ_STATUS_IDX) begin
      irqStatus_r <= (irqStatus_r & ~pwdata[1:0]) | irqEvt;
    end else begin
      irqStatus_r <= irqStatus_r | irqEvt;
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      irqMask_r <= IRQ_RST;
    end else if (softRst) begin
      irqMask_r <= IRQ_RST;
    end else if (wrStb && idx == IRQ_MASK_IDX) begin
      irqMask_r <= pwdata[1:0];
    end
  end
  assign irq = |(irqStatus_r & irqMask_r);
  // ----------------------------------------
  // read path
  // ----------------------------------------
  logic [7:0] rdByte;
  // clear and reset registers are write-only, so they read zero
  always_comb begin
    rdByte = 8'h00;
    case (idx)
      SUMMARY_IDX: rdByte = {6'h00, globalOpen, globalShort}; // R10
      OPEN_FLAGS_0_7_IDX: rdByte = openFlags_r[7:0];
      OPEN_FLAGS_8_15_IDX: rdByte = openFlags_r[15:8];
      OPEN_FLAGS_16_17_IDX: rdByte = {6'h00, openFlags_r[17:16]}; // R1
      SHORT_FLAGS_0_7_IDX: rdByte = shortFlags_r[7:0]; // R2
      SHORT_FLAGS_8_15_IDX: rdByte = shortFlags_r[15:8]; // R3
      SHORT_FLAGS_16_17_IDX: rdByte = {6'h00, shortFlags_r[17:16]}; // R4
      IRQ_STATUS_IDX: rdByte = {6'h00, irqStatus_r};
      IRQ_MASK_IDX: rdByte = {6'h00, irqMask_r};
      default: rdByte = 8'h00;
    endcase
  end
  // read data captured at the end of setup so it stands through the access phase;
  // a flag that sets during access shows on the next read, never half-way
  logic [31:0] prdata_r;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      prdata_r <= (!pwrite && hit) ? {24'h000000, rdByte} : 32'h00000000;
    end else if (!psel) begin
      prdata_r <= 32'h00000000;
    end
  end
  assign prdata = prdata_r;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence openClearCmd;
    psel && penable && pwrite && paddr == lfscByteAddr(OPEN_CLEAR_IDX) && pwdata[3:0] == CLEAR_CMD;
  endsequence

  sequence shortClearCmd;
    psel && penable && pwrite && paddr == lfscByteAddr(SHORT_CLEAR_IDX) && pwdata[3:0] == CLEAR_CMD;
  endsequence

  sequence rdAccess(logic [7:0] i);
    rdStb && idx == i;
  endsequence

  sequence statusWrite;
    wrStb && idx == IRQ_STATUS_IDX && !softRst;
  endsequence

  AST_OPEN_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // R5
    openClearCmd ##0 !softRst |=> openFlags_r == $past(det.open))
    else $error("open flags not cleared by clear command");

  AST_SHORT_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // R6
    shortClearCmd ##0 !softRst |=> shortFlags_r == $past(det.short))
    else $error("short flags not cleared by clear command");

  AST_SOFT_RESET: assert property (@(posedge clk) disable iff (!rstn) // R9
    softRst |=> openFlags_r == 18'h00000 && shortFlags_r == 18'h00000 && irqMask_r == 2'h0 && irqStatus_r == 2'h0)
    else $error("soft reset did not restore defaults");

  AST_STICKY_OPEN: assert property (@(posedge clk) disable iff (!rstn) // R11
    !clrOpen && !softRst |=> (openFlags_r & $past(openFlags_r)) == $past(openFlags_r))
    else $error("open flag dropped without clear");
  AST_STICKY_SHORT: assert property (@(posedge clk) disable iff (!rstn) // R11
    !clrShort && !softRst |=> (shortFlags_r & $past(shortFlags_r)) == $past(shortFlags_r))
    else $error("short flag dropped without clear");
  AST_SUMMARY: assert property (@(posedge clk) disable iff (!rstn) // R10
    globalOpen == (openFlags_r != 18'h00000) && globalShort == (shortFlags_r != 18'h00000))
    else $error("summary bits disagree with sink flags");
  AST_UPPER_ZERO: assert property (@(posedge clk) disable iff (!rstn) // R1
    rdStb && (idx == OPEN_FLAGS_16_17_IDX || idx == SHORT_FLAGS_16_17_IDX) |-> prdata[31:2] == 30'h0)
    else $error("reserved bits of third flag byte not zero");
  // ----------------------------------------
  // checks: read path, data taken at end of setup
  // ----------------------------------------

  AST_SHORT_LOW: assert property (@(posedge clk) disable iff (!rstn) // R2
    rdAccess(SHORT_FLAGS_0_7_IDX) |-> prdata[7:0] == $past(shortFlags_r[7:0]))
    else $error("short flags 0..7 misread");

  AST_SHORT_MID: assert property (@(posedge clk) disable iff (!rstn) // R3
    rdAccess(SHORT_FLAGS_8_15_IDX) |-> prdata[7:0] == $past(shortFlags_r[15:8]))
    else $error("short flags 8..15 misread");

  AST_SHORT_HIGH: assert property (@(posedge clk) disable iff (!rstn) // R4
    rdAccess(SHORT_FLAGS_16_17_IDX) |-> prdata[1:0] == $past(shortFlags_r[17:16]))
    else $error("short flags 16..17 misread");

  AST_OPEN_LOW: assert property (@(posedge clk) disable iff (!rstn) // R11
    rdAccess(OPEN_FLAGS_0_7_IDX) |-> prdata[7:0] == $past(openFlags_r[7:0]))
    else $error("open flags 0..7 misread");

  AST_OPEN_MID: assert property (@(posedge clk) disable iff (!rstn) // R11
    rdAccess(OPEN_FLAGS_8_15_IDX) |-> prdata[7:0] == $past(openFlags_r[15:8]))
    else $error("open flags 8..15 misread");

  AST_OPEN_HIGH: assert property (@(posedge clk) disable iff (!rstn) // R1
    rdAccess(OPEN_FLAGS_16_17_IDX) |-> prdata[1:0] == $past(openFlags_r[17:16]))
    else $error("open flags 16..17 misread");

  AST_SUMMARY_READ: assert property (@(posedge clk) disable iff (!rstn) // R10
    rdAccess(SUMMARY_IDX) |-> prdata[1:0] == $past({globalOpen, globalShort}) && prdata[31:2] == 30'h0)
    else $error("summary register misread");

  AST_WO_READ_ZERO: assert property (@(posedge clk) disable iff (!rstn) // R8
    rdStb && (idx == OPEN_CLEAR_IDX || idx == SHORT_CLEAR_IDX || idx == SOFT_RESET_IDX) |-> prdata == 32'h0)
    else $error("write-only register read non-zero");

  AST_PRDATA_IDLE: assert property (@(posedge clk) disable iff (!rstn)
    !psel |=> prdata == 32'h0)
    else $error("read data not zero between transfers");

  AST_ZERO_WAIT: assert property (@(posedge clk) disable iff (!rstn)
    psel && penable |-> pready)
    else $error("access phase not answered at once");

  AST_ERR_UNMAPPED: assert property (@(posedge clk) disable iff (!rstn)
    psel && penable && !hit |-> pslverr && !wrStb && !rdStb)
    else $error("unmapped access not refused");

  // ----------------------------------------
  // checks: clear values and detection
  // ----------------------------------------

  AST_BAD_CLEAR: assert property (@(posedge clk) disable iff (!rstn) // R11
    wrStb && idx == OPEN_CLEAR_IDX && pwdata[3:0] != CLEAR_CMD && !softRst |=>
      (openFlags_r & $past(openFlags_r)) == $past(openFlags_r))
    else $error("non-Fh clear value changed open flags");

  AST_BAD_CLEAR_SHORT: assert property (@(posedge clk) disable iff (!rstn) // R11
    wrStb && idx == SHORT_CLEAR_IDX && pwdata[3:0] != CLEAR_CMD && !softRst |=>
      (shortFlags_r & $past(shortFlags_r)) == $past(shortFlags_r))
    else $error("non-Fh clear value changed short flags");

  AST_DETECT_OPEN: assert property (@(posedge clk) disable iff (!rstn) // R11
    !softRst |=> (openFlags_r & $past(det.open)) == $past(det.open))
    else $error("detected open fault not flagged");

  AST_DETECT_SHORT: assert property (@(posedge clk) disable iff (!rstn) // R11
    !softRst |=> (shortFlags_r & $past(det.short)) == $past(det.short))
    else $error("detected short fault not flagged");

  // ----------------------------------------
  // checks: interrupt status and mask
  // ----------------------------------------

  AST_STATUS_W1C: assert property (@(posedge clk) disable iff (!rstn)
    statusWrite |=> (irqStatus_r & $past(pwdata[1:0]) & ~$past(irqEvt)) == 2'h0)
    else $error("status bit not cleared by writing one");

  AST_STATUS_SET_WINS: assert property (@(posedge clk) disable iff (!rstn)
    irqEvt != 2'h0 && !softRst |=> (irqStatus_r & $past(irqEvt)) == $past(irqEvt))
    else $error("event lost against status clear");

  AST_MASK_WRITE: assert property (@(posedge clk) disable iff (!rstn)
    wrStb && idx == IRQ_MASK_IDX && !softRst |=> irqMask_r == $past(pwdata[1:0]))
    else $error("mask write not taken");

  AST_ERR_NO_EFFECT: assert property (@(posedge clk) disable iff (!rstn)
    pslverr |=> irqMask_r == $past(irqMask_r))
    else $error("refused access changed the mask");

  AST_IRQ_LEVEL: assert property (@(posedge clk) disable iff (!rstn)
    $rose(irqStatus_r[IRQ_OPEN_BIT]) && irqMask_r[IRQ_OPEN_BIT] |-> irq)
    else $error("interrupt not raised for unmasked event");
endmodule : lfsc_fault_regs

// >>> lfsc_fault_regs_tb.sv
// self-checking bench for the led fault flag and clear register bank
// assumes zero-wait apb answers and a three-edge detector path
`timescale 1ns/1ps
module lfsc_fault_regs_tb import lfsc_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  lfsc_fault_t faultIn = '0;
  logic [31:0] prdata;
  logic pready, pslverr, globalOpen, globalShort, irq;
  int errors = 0;
  int nCompared = 0;
  integer seed = 84;
  logic [33:0] expQ[$];
  logic [33:0] note;
  logic [63:0] rnd;
  logic [17:0] openExp = '0;
  logic [17:0] shortExp = '0;
  logic [7:0] badClr[4] = '{8'h0e, 8'hf0, 8'h07, 8'h00};
  lfsc_fault_regs dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .faultIn(faultIn), .globalOpen(globalOpen), .globalShort(globalShort), .irq(irq));
  initial begin
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // compares and bus tasks
  // ----------------------------------------
  task automatic cmpWord(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: read data %h, wanted %h", $time, got, exp);
    end
  endtask : cmpWord
  task automatic cmpBit(input logic got, input logic exp, input string what);
    nCompared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s is %b, wanted %b", $time, what, got, exp);
    end
  endtask : cmpBit
  // one idle cycle between transfers keeps each strobe to one driver per step
  task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd, input logic [31:0] exp,
                      input logic err);
    int n;
    n = 0;
    @(posedge clk);
    expQ.push_back({wr, err, exp});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00, exp, 1'b0);
  endtask : rd
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(1'b1, idx, d, 32'h0, 1'b0);
  endtask : wr
  task automatic settle;
    @(posedge clk);
    #1;
  endtask : settle
  task automatic inject(input lfsc_fault_t f);
    @(posedge clk);
    faultIn <= f;
    repeat (4) @(posedge clk);
    faultIn <= '0;
    repeat (4) @(posedge clk);
    openExp = openExp | f.open;
    shortExp = shortExp | f.short;
  endtask : inject
  task automatic checkAll;
    rd(SUMMARY_IDX, {30'h0, |openExp, |shortExp});
    rd(OPEN_FLAGS_0_7_IDX, {24'h0, openExp[7:0]});
    rd(OPEN_FLAGS_8_15_IDX, {24'h0, openExp[15:8]});
    rd(OPEN_FLAGS_16_17_IDX, {30'h0, openExp[17:16]});
    rd(SHORT_FLAGS_0_7_IDX, {24'h0, shortExp[7:0]});
    rd(SHORT_FLAGS_8_15_IDX, {24'h0, shortExp[15:8]});
    rd(SHORT_FLAGS_16_17_IDX, {30'h0, shortExp[17:16]});
    settle;
    cmpBit(globalOpen, |openExp, "global open");
    cmpBit(globalShort, |shortExp, "global short");
  endtask : checkAll
  task automatic wrap_up;
    if (errors == 0 && nCompared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------
  // monitor, watchdog, sequence
  // ----------------------------------------
  always @(posedge clk) begin
    if (rstn && psel && penable && pready) begin
      if (expQ.size() == 0) begin
        errors++;
        $display("unexpected at %0t: transfer with nothing expected", $time);
      end else begin
        note = expQ.pop_front();
        if (!note[33]) cmpWord(prdata, note[31:0]);
        cmpBit(pslverr, note[32], "error response");
      end
    end
  end
  initial begin
    #100us;
    errors++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    checkAll();
    rd(OPEN_CLEAR_IDX, 32'h0);
    rd(SHORT_CLEAR_IDX, 32'h0);
    for (int i = 0; i < 3; i++) begin
      rnd = {$random(seed), $random(seed)};
      inject(rnd[35:0]);
      checkAll();
    end
    wr(SHORT_FLAGS_0_7_IDX, 8'h00);
    wr(OPEN_FLAGS_16_17_IDX, 8'h00);
    inject({18'h30000, 18'h30001});
    checkAll();
    cmpBit(irq, 1'b0, "irq masked");
    rd(IRQ_STATUS_IDX, 32'h3);
    wr(IRQ_MASK_IDX, 8'h03);
    settle();
    cmpBit(irq, 1'b1, "irq raised");
    wr(IRQ_MASK_IDX, 8'h01);
    wr(IRQ_STATUS_IDX, 8'h01);
    settle();
    cmpBit(irq, 1'b0, "irq after clear");
    // clear values other than a full low nibble must leave every flag alone
    foreach (badClr[k]) begin
      wr(OPEN_CLEAR_IDX, badClr[k]);
      wr(SHORT_CLEAR_IDX, badClr[k]);
    end
    checkAll();
    wr(OPEN_CLEAR_IDX, 8'hff);
    openExp = '0;
    checkAll();
    wr(SHORT_CLEAR_IDX, {4'h0, CLEAR_CMD});
    shortExp = '0;
    checkAll();
    xfer(1'b0, 8'haa, 8'h00, 32'h0, 1'b1);
    xfer(1'b1, 8'h70, 8'hff, 32'h0, 1'b1);
    inject({18'h20001, 18'h00080});
    wr(IRQ_MASK_IDX, 8'h03);
    rd(IRQ_MASK_IDX, 32'h3);
    wr(SOFT_RESET_IDX, 8'hff);
    openExp = '0;
    shortExp = '0;
    checkAll();
    cmpBit(irq, 1'b0, "irq after soft reset");
    rd(IRQ_MASK_IDX, 32'h0);
    rd(IRQ_STATUS_IDX, 32'h0);
    wrap_up();
  end
endmodule : lfsc_fault_regs_tb
